// ---- core/qerm_pkg.sv ----
// Package of constants and carrier types for the queue event routing map.
package qerm_pkg;
    localparam int QERM_STARVE_BASE = 8928;
    localparam int QERM_STARVE_NUM = 64;
    localparam int QERM_HP2_BASE = 8896;
    localparam int QERM_HP_NUM = 32;
    localparam int QERM_LP_BLOCK = 32;
    localparam int QERM_LP_NUM = 16;
    localparam int QERM_LP_EVENT_BASE = 32;
    localparam int QERM_HP_EVENT_BASE = 48;
    localparam int QERM_HPX_EVENT_BASE = 102;
    localparam int QERM_HP_SUGGEST_BASE = 704;
    localparam int QERM_QP4_FIRST_Q = 662;
    localparam int QERM_QP4_FIRST_IN = 134;
    localparam int QERM_QP4_LAST_Q = 671;
    localparam int QERM_QP4_LAST_IN = 175;
    localparam int QERM_QP8_C0_FIRST_Q = 652;
    localparam int QERM_QP8_C1_FIRST_Q = 658;
    localparam int QERM_DMA2_FIRST_Q = 8992;
    localparam int QERM_DMA2_NUM = 32;
    localparam int QERM_LINK2_FIRST_Q = 8864;
    localparam int QERM_LINK2_NUM = 16;
    localparam int QERM_GP_FIRST_Q = 9024;
    localparam int QERM_GP_LAST_Q = 16383;
    localparam int QERM_QPEND_NUM = 20;
    localparam int QERM_QPEND_BASE_Q = 652;
    localparam int QERM_CNT_W = 16;
    localparam logic [15:0] QERM_CNT_RST = 16'h0000;
    localparam int QERM_CORE_EVENTS = 128;
    localparam int QERM_CTRL_INPUTS = 256;

    typedef enum logic [1:0] {
        QERM_VAR_FOUR = 2'b00,
        QERM_VAR_TWO = 2'b01,
        QERM_VAR_EIGHT = 2'b11
    } qerm_variant_t;

    typedef struct packed {
        logic valid;
        logic [5:0] index;
    } qerm_starve_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] count;
    } qerm_starve_rsp_t;
endpackage : qerm_pkg

// ---- core/qerm_starve_mem.sv ----
// Starvation counter memory: per-queue counters with read-and-clear.
`timescale 1ns/1ps
`default_nettype none
module qerm_starve_mem #(
    parameter int DEPTH = 64,
    parameter int CW = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [DEPTH-1:0] pop_empty,
    input wire logic rd_en,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [CW-1:0] rd_data,
    output logic rd_valid
);
    import qerm_pkg::*;
    logic [CW-1:0] cnt_r [DEPTH];

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_cnt
            logic clr;
            assign clr = rd_en && (rd_idx == ($clog2(DEPTH))'(g));
            // count and clear
            // A pop in the read cycle is kept: it lands as a count of one.
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    cnt_r[g] <= CW'(QERM_CNT_RST);
                end else if (clr) begin
                    cnt_r[g] <= pop_empty[g] ? CW'(1) : '0;
                end else if (pop_empty[g] && cnt_r[g] != '1) begin
                    cnt_r[g] <= cnt_r[g] + CW'(1);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= '0;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= cnt_r[rd_idx];
            end
        end
    end
endmodule : qerm_starve_mem
`default_nettype wire

// ---- core/qerm_top.sv ----
// Fixed routing of queue manager queues onto interrupt and core event lines.
`timescale 1ns/1ps
`default_nettype none
module qerm_top #(
    parameter int NCORE = 8,
    parameter qerm_pkg::qerm_variant_t VARIANT = qerm_pkg::QERM_VAR_FOUR
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [qerm_pkg::QERM_HP_NUM-1:0] high_prio_accum_irq,
    input wire logic [qerm_pkg::QERM_HP_NUM-1:0] high_prio_accum_irq_qm2,
    input wire logic [qerm_pkg::QERM_LP_NUM-1:0] low_prio_accum_irq,
    input wire logic [qerm_pkg::QERM_QPEND_NUM-1:0] queue_nonempty,
    input wire logic [qerm_pkg::QERM_DMA2_NUM-1:0] dma2_queue_nonempty,
    input wire logic [qerm_pkg::QERM_LINK2_NUM-1:0] link2_queue_nonempty,
    input wire logic [qerm_pkg::QERM_STARVE_NUM-1:0] starve_pop_empty,
    input wire qerm_pkg::qerm_starve_req_t starve_req,
    output qerm_pkg::qerm_starve_rsp_t starve_rsp,
    output logic [NCORE-1:0][qerm_pkg::QERM_CORE_EVENTS-1:0] core_event,
    output logic [qerm_pkg::QERM_CTRL_INPUTS-1:0] first_chip_irq_controller,
    output logic [qerm_pkg::QERM_CTRL_INPUTS-1:0] second_chip_irq_controller,
    output logic [qerm_pkg::QERM_DMA2_NUM-1:0] second_infra_packet_dma_txq_pend,
    output logic [qerm_pkg::QERM_LINK2_NUM-1:0] second_link_queue_pending_line
);
    import qerm_pkg::*;

    // Pins from the queue manager arrive on the same clock, so no synchroniser.
    logic [NCORE-1:0][QERM_CORE_EVENTS-1:0] ev_nxt;
    logic [QERM_CTRL_INPUTS-1:0] c0_nxt;
    logic [QERM_CTRL_INPUTS-1:0] c1_nxt;
    logic [15:0] c8_in [14];
    logic [15:0] rd_cnt;
    logic rd_vld;

    // Controller input numbers shared by both controllers in the eight-core wiring.
    assign c8_in[0] = 16'h002f;
    assign c8_in[1] = 16'h005b;
    assign c8_in[2] = 16'h005d;
    assign c8_in[3] = 16'h005f;
    assign c8_in[4] = 16'h0061;
    generate
        for (genvar i = 5; i < 14; i++) begin : g_c8
            assign c8_in[i] = 16'(151 + i - 5);
        end
    endgenerate

    always_comb begin
        ev_nxt = '0;
        for (int n = 0; n < NCORE; n++) begin
            for (int c = 0; c < QERM_LP_NUM; c++) begin
                ev_nxt[n][QERM_LP_EVENT_BASE + c] = low_prio_accum_irq[c];
            end
            if (VARIANT == QERM_VAR_EIGHT) begin
                for (int k = 0; k < 4; k++) begin
                    if (n + 8 * k < QERM_HP_NUM) begin
                        ev_nxt[n][QERM_HP_EVENT_BASE + k] = high_prio_accum_irq[n + 8 * k];
                        ev_nxt[n][QERM_HP_EVENT_BASE + 4 + k] = high_prio_accum_irq_qm2[n + 8 * k];
                    end
                end
            end else if (n < 4) begin
                for (int k = 0; k < 8; k++) begin
                    ev_nxt[n][QERM_HP_EVENT_BASE + k] = high_prio_accum_irq[n + 4 * k];
                end
                if (VARIANT == QERM_VAR_TWO && n < 2) begin
                    for (int k = 0; k < 8; k++) begin
                        ev_nxt[n][QERM_HPX_EVENT_BASE + k] = high_prio_accum_irq[n + 2 + 4 * k];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_event <= '0;
        end else begin
            core_event <= ev_nxt;
        end
    end

    always_comb begin
        c0_nxt = '0;
        c1_nxt = '0;
        if (VARIANT == QERM_VAR_EIGHT) begin
            for (int i = 0; i < 14; i++) begin
                c0_nxt[c8_in[i][7:0]] = queue_nonempty[QERM_QP8_C0_FIRST_Q - QERM_QPEND_BASE_Q + i];
                c1_nxt[c8_in[i][7:0]] = queue_nonempty[QERM_QP8_C1_FIRST_Q - QERM_QPEND_BASE_Q + i];
            end
        end else begin
            for (int i = 0; i < QERM_QP4_LAST_Q - QERM_QP4_FIRST_Q; i++) begin
                c0_nxt[QERM_QP4_FIRST_IN + i] = queue_nonempty[QERM_QP4_FIRST_Q - QERM_QPEND_BASE_Q + i];
            end
            c0_nxt[QERM_QP4_LAST_IN] = queue_nonempty[QERM_QP4_LAST_Q - QERM_QPEND_BASE_Q];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            first_chip_irq_controller <= '0;
            second_chip_irq_controller <= '0;
        end else begin
            first_chip_irq_controller <= c0_nxt;
            second_chip_irq_controller <= c1_nxt;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            second_infra_packet_dma_txq_pend <= '0;
            second_link_queue_pending_line <= '0;
        end else begin
            second_infra_packet_dma_txq_pend <= dma2_queue_nonempty;
            second_link_queue_pending_line <= link2_queue_nonempty;
        end
    end

    qerm_starve_mem #(
        .DEPTH(QERM_STARVE_NUM),
        .CW(QERM_CNT_W)
    ) u_starve (
        .clk(clk),
        .sys_rst(sys_rst),
        .pop_empty(starve_pop_empty),
        .rd_en(starve_req.valid),
        .rd_idx(starve_req.index),
        .rd_data(rd_cnt),
        .rd_valid(rd_vld)
    );

    always_comb begin
        starve_rsp.valid = rd_vld;
        starve_rsp.count = rd_cnt;
    end

    pend_level_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> second_link_queue_pending_line == $past(link2_queue_nonempty))
        else $error("link pending does not follow queue level");

    dma_pend_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> second_infra_packet_dma_txq_pend == $past(dma2_queue_nonempty))
        else $error("dma pending does not follow queue level");

    lp_bcast_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> core_event[0][47:32] == $past(low_prio_accum_irq)
            && core_event[NCORE-1][47:32] == $past(low_prio_accum_irq))
        else $error("low priority event not broadcast");

    hp_route_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> core_event[1][49] == (VARIANT == QERM_VAR_EIGHT ? $past(high_prio_accum_irq[9])
            : $past(high_prio_accum_irq[5])))
        else $error("high priority channel misrouted");

    hp_extra_a: assert property (@(posedge clk) disable iff (sys_rst)
        VARIANT == QERM_VAR_TWO |=> core_event[0][102] == $past(high_prio_accum_irq[2]))
        else $error("extra high priority event misrouted");

    ctrl_wire_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> (VARIANT == QERM_VAR_EIGHT) ? (first_chip_irq_controller[47] == $past(queue_nonempty[0])
            && second_chip_irq_controller[159] == $past(queue_nonempty[19]))
            : (first_chip_irq_controller[175] == $past(queue_nonempty[19])
            && first_chip_irq_controller[134] == $past(queue_nonempty[10])))
        else $error("controller input wiring wrong");

    sequence starve_rd_s;
        starve_req.valid;
    endsequence

    rd_answer_a: assert property (@(posedge clk) disable iff (sys_rst)
        starve_rd_s |=> starve_rsp.valid)
        else $error("starvation read not answered");

    rd_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        starve_rd_s ##1 (starve_req.valid && $past(starve_req.index) == starve_req.index
            && !$past(starve_pop_empty[starve_req.index]) && !starve_pop_empty[starve_req.index])
        |=> starve_rsp.count == '0)
        else $error("starvation count not cleared by read");

    // The checks below pin single routes in every variant, so a swapped index shows up
    // even where the bench drives only one variant at a time.

    rsp_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
        !starve_req.valid |=> !starve_rsp.valid)
        else $error("starvation answer without a read");

    sequence starve_twice_s;
        starve_rd_s ##1 starve_rd_s;
    endsequence

    rd_twice_a: assert property (@(posedge clk) disable iff (sys_rst)
        starve_twice_s |-> starve_rsp.valid ##1 starve_rsp.valid)
        else $error("back to back starvation reads not both answered");

    lp_first_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> core_event[0][32] == $past(low_prio_accum_irq[0]))
        else $error("low priority channel zero misrouted");

    hp_first_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> core_event[0][48] == $past(high_prio_accum_irq[0]))
        else $error("high priority channel zero misrouted");

    hp_top_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> core_event[1][55] == (VARIANT == QERM_VAR_EIGHT ? $past(high_prio_accum_irq_qm2[25])
            : $past(high_prio_accum_irq[29])))
        else $error("high priority event 55 misrouted");

    qm2_route_a: assert property (@(posedge clk) disable iff (sys_rst)
        VARIANT == QERM_VAR_EIGHT |=> core_event[0][52] == $past(high_prio_accum_irq_qm2[0]))
        else $error("second manager channel misrouted");

    hp_extra_top_a: assert property (@(posedge clk) disable iff (sys_rst)
        VARIANT == QERM_VAR_TWO |=> core_event[1][109] == $past(high_prio_accum_irq[31]))
        else $error("last extra high priority event misrouted");

    no_extra_a: assert property (@(posedge clk) disable iff (sys_rst)
        VARIANT != QERM_VAR_TWO |=> core_event[0][109:102] == 8'h00)
        else $error("extra events raised outside the small variant");

    low_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> core_event[0][31:0] == 32'h0000_0000)
        else $error("unmapped core event raised");

    ctrl1_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
        VARIANT != QERM_VAR_EIGHT |=> second_chip_irq_controller == '0)
        else $error("second controller driven outside eight-core wiring");

    ctrl_mid_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> (VARIANT == QERM_VAR_EIGHT) ? (first_chip_irq_controller[159] == $past(queue_nonempty[13]))
            : (first_chip_irq_controller[142] == $past(queue_nonempty[18])))
        else $error("middle controller input wiring wrong");

    ctrl1_first_a: assert property (@(posedge clk) disable iff (sys_rst)
        VARIANT == QERM_VAR_EIGHT |=> second_chip_irq_controller[47] == $past(queue_nonempty[6]))
        else $error("second controller first input wiring wrong");

    sequence link_rise_s;
        $rose(link2_queue_nonempty[0]);
    endsequence

    sequence dma_fall_s;
        $fell(dma2_queue_nonempty[0]);
    endsequence

    link_rise_a: assert property (@(posedge clk) disable iff (sys_rst)
        link_rise_s |=> $rose(second_link_queue_pending_line[0]))
        else $error("link pending did not rise with its queue");

    dma_fall_a: assert property (@(posedge clk) disable iff (sys_rst)
        dma_fall_s |=> $fell(second_infra_packet_dma_txq_pend[0]))
        else $error("dma pending did not drop when its queue emptied");
endmodule : qerm_top
`default_nettype wire

// ---- dv/qerm_intc_model.sv ----
// Behavioural chip-level controller channel with input select and enable.
`timescale 1ns/1ps
`default_nettype none
module qerm_intc_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [255:0] sys_in,
    input wire logic [7:0] route_sel,
    input wire logic route_en,
    output logic chan_out
);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            chan_out <= 1'b0;
        end else begin
            chan_out <= route_en & sys_in[route_sel];
        end
    end
endmodule : qerm_intc_model
`default_nettype wire

// ---- dv/qerm_tb_top.sv ----
// Self-checking testbench for the queue event routing map, four-, two- and eight-core variants.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module qerm_tb_top;
    import qerm_pkg::*;
    localparam int NC = 4;
    logic clk, sys_rst, route_en, chan_out;
    logic [31:0] hp, dma2;
    logic [15:0] lp, link2;
    logic [19:0] qne;
    logic [63:0] pop;
    logic [7:0] route_sel;
    qerm_starve_req_t req;
    qerm_starve_rsp_t rsp;
    logic [NC-1:0][127:0] ev, exp_ev;
    logic [255:0] ctl0, ctl1, exp_ctl;
    logic [31:0] dma_pend;
    logic [15:0] link_pend;
    logic [31:0] hp2;
    logic [1:0][127:0] ev2, exp_ev2;
    logic [7:0][127:0] ev8, exp_ev8;
    logic [255:0] c80, c81, exp_c1;
    localparam int IN8 [14] = '{47, 91, 93, 95, 97, 151, 152, 153, 154, 155, 156, 157, 158, 159};
    int miscompares = 0;
    int samples_checked = 0;

    qerm_top #(.NCORE(NC), .VARIANT(QERM_VAR_FOUR)) uut (.clk(clk), .sys_rst(sys_rst),
        .high_prio_accum_irq(hp), .high_prio_accum_irq_qm2(32'h0000_0000), .low_prio_accum_irq(lp),
        .queue_nonempty(qne), .dma2_queue_nonempty(dma2), .link2_queue_nonempty(link2),
        .starve_pop_empty(pop), .starve_req(req), .starve_rsp(rsp), .core_event(ev),
        .first_chip_irq_controller(ctl0), .second_chip_irq_controller(ctl1),
        .second_infra_packet_dma_txq_pend(dma_pend), .second_link_queue_pending_line(link_pend));
    qerm_intc_model partner (.clk(clk), .sys_rst(sys_rst), .sys_in(ctl0), .route_sel(route_sel),
        .route_en(route_en), .chan_out(chan_out));
    qerm_top #(.NCORE(2), .VARIANT(QERM_VAR_TWO)) uut_two (.clk(clk), .sys_rst(sys_rst),
        .high_prio_accum_irq(hp), .high_prio_accum_irq_qm2(hp2), .low_prio_accum_irq(lp),
        .queue_nonempty(qne), .dma2_queue_nonempty(dma2), .link2_queue_nonempty(link2),
        .starve_pop_empty(pop), .starve_req(req), .starve_rsp(), .core_event(ev2),
        .first_chip_irq_controller(), .second_chip_irq_controller(),
        .second_infra_packet_dma_txq_pend(), .second_link_queue_pending_line());
    qerm_top #(.NCORE(8), .VARIANT(QERM_VAR_EIGHT)) uut_eight (.clk(clk), .sys_rst(sys_rst),
        .high_prio_accum_irq(hp), .high_prio_accum_irq_qm2(hp2), .low_prio_accum_irq(lp),
        .queue_nonempty(qne), .dma2_queue_nonempty(dma2), .link2_queue_nonempty(link2),
        .starve_pop_empty(pop), .starve_req(req), .starve_rsp(), .core_event(ev8),
        .first_chip_irq_controller(c80), .second_chip_irq_controller(c81),
        .second_infra_packet_dma_txq_pend(), .second_link_queue_pending_line());

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Inputs change at the falling edge; registered outputs are settled by the next one.
    task step;
        @(posedge clk);
        @(negedge clk);
    endtask : step

    task wrap_up;
        $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    task t_high_prio;
        for (int ch = 0; ch < 32; ch++) begin
            hp = 32'h1 << ch;
            step();
            exp_ev = '0;
            exp_ev[ch % 4][48 + ch / 4] = 1'b1;
            `CHK(ev, exp_ev)
        end
        hp = '0;
    endtask : t_high_prio

    task t_low_prio;
        for (int c = 0; c < 16; c++) begin
            lp = 16'h1 << c;
            step();
            exp_ev = '0;
            for (int n = 0; n < NC; n++) exp_ev[n][32 + c] = 1'b1;
            `CHK(ev, exp_ev)
        end
        lp = '0;
    endtask : t_low_prio

    // Small variant: channels N+2+4k land on events 102+k of cores 0 and 1.
    task t_two;
        for (int ch = 0; ch < 32; ch++) begin
            hp = 32'h1 << ch;
            step();
            exp_ev2 = '0;
            if (ch % 4 < 2) begin
                exp_ev2[ch % 4][48 + ch / 4] = 1'b1;
            end else begin
                exp_ev2[ch % 4 - 2][102 + ch / 4] = 1'b1;
            end
            `CHK(ev2, exp_ev2)
        end
        hp = '0;
    endtask : t_two

    // Eight-core wiring: both managers' channels and both controllers.
    task t_eight;
        for (int ch = 0; ch < 32; ch++) begin
            hp = 32'h1 << ch;
            hp2 = 32'h8000_0000 >> ch;
            step();
            exp_ev8 = '0;
            exp_ev8[ch % 8][48 + ch / 8] = 1'b1;
            exp_ev8[(31 - ch) % 8][52 + (31 - ch) / 8] = 1'b1;
            `CHK(ev8, exp_ev8)
        end
        hp = '0;
        hp2 = '0;
        step();
        for (int i = 0; i < 20; i++) begin
            qne = 20'h1 << i;
            step();
            exp_ctl = '0;
            exp_c1 = '0;
            if (i < 14) begin
                exp_ctl[IN8[i]] = 1'b1;
            end
            if (i >= 6) begin
                exp_c1[IN8[i - 6]] = 1'b1;
            end
            `CHK(c80, exp_ctl)
            `CHK(c81, exp_c1)
        end
        qne = '0;
    endtask : t_eight

    task t_qpend;
        for (int i = 10; i < 20; i++) begin
            qne = 20'h1 << i;
            step();
            exp_ctl = '0;
            exp_ctl[(i == 19) ? 175 : 124 + i] = 1'b1;
            `CHK(ctl0, exp_ctl)
            `CHK(ctl1, 256'h0)
        end
        qne = 20'h0_2000;
        route_sel = 8'h89;
        route_en = 1'b1;
        step();
        step();
        `CHK(chan_out, 1'b1)
        qne = '0;
        step();
        `CHK(ctl0, 256'h0)
        step();
        `CHK(chan_out, 1'b0)
        route_en = 1'b0;
    endtask : t_qpend

    task t_pend;
        dma2 = 32'ha5a5_0f0f;
        link2 = 16'h8001;
        step();
        `CHK(dma_pend, 32'ha5a5_0f0f)
        `CHK(link_pend, 16'h8001)
        dma2 = '0;
        link2 = '0;
        step();
        `CHK({dma_pend, link_pend}, 48'h0)
    endtask : t_pend

    // Back-to-back reads of one index: the first returns the count, the second sees it cleared.
    task t_starve(input int idx, input int n);
        for (int k = 0; k < n; k++) begin
            pop = 64'h1 << idx;
            step();
            pop = '0;
            step();
        end
        req = '{valid: 1'b1, index: 6'(idx)};
        step();
        `CHK(rsp, qerm_starve_rsp_t'({1'b1, 16'(n)}))
        step();
        req = '0;
        `CHK(rsp, qerm_starve_rsp_t'({1'b1, 16'h0000}))
        step();
        `CHK(rsp.valid, 1'b0)
    endtask : t_starve

    initial begin
        sys_rst = 1'b1;
        {hp, hp2, lp, qne, dma2, link2, pop, route_sel, route_en} = '0;
        req = '0;
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        `CHK({ev, ctl0, ctl1, rsp}, '0)
        t_high_prio();
        t_low_prio();
        t_two();
        t_qpend();
        t_pend();
        t_starve(0, 3);
        t_starve(63, 5);
        t_eight();
        wrap_up();
    end
endmodule : qerm_tb_top
`default_nettype wire
